// >>> design/daa_pkg.sv
// Shared constants and types for the line-side bring-up block
package daa_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BIT_DIV = 16;
  localparam int FRAME_BITS = 40;
  localparam int RATE_BASE_HZ = 7200;
  localparam int RATE_STEP_HZ = 400;
  localparam int CORNER01_NUM = 33;
  localparam int CORNER01_DEN = 80;
  localparam int CORNER3_NUM = 9;
  localparam int CORNER3_DEN = 20;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_INT_MASK = 6'h03;
  localparam logic [5:0] IDX_INT_STATUS = 6'h04;
  localparam logic [5:0] IDX_HOOK = 6'h05;
  localparam logic [5:0] IDX_POWER = 6'h06;
  localparam logic [5:0] IDX_RATE = 6'h07;
  localparam logic [5:0] IDX_CORNER = 6'h08;
  localparam logic [5:0] IDX_LINE_STATUS = 6'h0c;
  localparam logic [5:0] IDX_RX_MON = 6'h14;
  localparam logic [5:0] IDX_TX_MON = 6'h15;

  localparam int INT_DROPOUT_BIT = 3;
  localparam int INT_OVERLOAD_BIT = 2;
  localparam int HOOK_OFF_BIT = 0;
  localparam int HOOK_RING_BIT = 2;
  localparam int POWERDOWN_BIT = 4;
  localparam int READY_BIT = 6;
  localparam int CID_BIT = 5;
  localparam int LOOP_W = 5;
  localparam int RATE_W = 4;

  localparam logic POWERDOWN_RESET = 1'b1;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [7:0] MON_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [4:0] LOOP_MAX = 5'h1f;

  // Outbound frame: sample, rx monitor, tx monitor, rate, hook, pad
  localparam int TXF_SAMPLE = 24;
  localparam int TXF_RXMON = 16;
  localparam int TXF_TXMON = 8;
  localparam int TXF_RATE = 4;
  localparam int TXF_HOOK = 3;
  // Inbound frame: sample, loop code, ring, caller id, dropout
  localparam int RXF_SAMPLE = 24;
  localparam int RXF_LOOP = 19;
  localparam int RXF_RING = 18;
  localparam int RXF_CID = 17;
  localparam int RXF_DROP = 16;

  typedef enum logic [1:0] {
    PWR_DOWN = 2'b00,
    PWR_SETTLE = 2'b01,
    PWR_READY = 2'b10
  } power_state_t;
endpackage

// >>> design/link_if.sv
// Frame exchange between the register core and the isolation link shifter
`timescale 1ns/1ps
`default_nettype none
interface link_if #(parameter int FRAME_BITS = daa_pkg::FRAME_BITS);
  logic enable;
  logic [FRAME_BITS-1:0] tx_frame;
  logic [FRAME_BITS-1:0] rx_frame;
  logic frame_done;
  modport ctrl(output enable, output tx_frame, input rx_frame, input frame_done);
  modport phy(input enable, input tx_frame, output rx_frame, output frame_done);
endinterface
`default_nettype wire

// >>> design/isolation_link.sv
// Serial shifter carrying whole frames across the isolation link
`timescale 1ns/1ps
`default_nettype none
module isolation_link #(
  parameter int BIT_DIV = daa_pkg::BIT_DIV,
  parameter int FRAME_BITS = daa_pkg::FRAME_BITS
) (
  input wire logic clk,
  input wire logic rst,
  link_if.phy lnk,
  input wire logic line_rx,
  output logic line_tx,
  output logic line_sclk,
  output logic line_fsync
);
  if (BIT_DIV < 2 || BIT_DIV > 65535 || FRAME_BITS < 8 || FRAME_BITS > 255) begin : g_chk
    $error("isolation_link: unsupported BIT_DIV or FRAME_BITS");
  end

  logic [15:0] div_reg, div_next;
  logic [7:0] bit_reg, bit_next;
  logic [FRAME_BITS-1:0] shtx_reg, shtx_next, shrx_reg, shrx_next, rxf_reg, rxf_next;
  logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
  logic tx_reg, tx_next, sclk_reg, sclk_next, fs_reg, fs_next, done_reg, done_next;
  logic bit_en;

  assign bit_en = (div_reg == 16'(BIT_DIV - 1));

  always_comb begin
    div_next = div_reg;
    bit_next = bit_reg;
    shtx_next = shtx_reg;
    shrx_next = shrx_reg;
    rxf_next = rxf_reg;
    tx_next = tx_reg;
    fs_next = fs_reg;
    done_next = 1'b0;
    // Filtered pin level moves only when the last two stages agree
    lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    sclk_next = 1'b0;
    if (lnk.enable) begin
      div_next = bit_en ? 16'h0000 : div_reg + 16'h0001;
      sclk_next = (div_reg >= 16'(BIT_DIV / 2));
      if (bit_en) begin
        if (bit_reg == 8'h00) begin
          tx_next = lnk.tx_frame[FRAME_BITS-1];
          shtx_next = lnk.tx_frame << 1;
        end else begin
          tx_next = shtx_reg[FRAME_BITS-1];
          shtx_next = shtx_reg << 1;
        end
        fs_next = (bit_reg == 8'h00);
        shrx_next = {shrx_reg[FRAME_BITS-2:0], lvl_reg};
        if (bit_reg == 8'(FRAME_BITS - 1)) begin
          bit_next = 8'h00;
          rxf_next = {shrx_reg[FRAME_BITS-2:0], lvl_reg};
          done_next = 1'b1;
        end else begin
          bit_next = bit_reg + 8'h01;
        end
      end
    end else begin
      div_next = 16'h0000;
      bit_next = 8'h00;
      tx_next = 1'b0;
      fs_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s1_reg <= line_rx;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (rst) begin
      div_reg <= 16'h0000;
      bit_reg <= 8'h00;
      shtx_reg <= '0;
      shrx_reg <= '0;
      rxf_reg <= '0;
      lvl_reg <= 1'b0;
      tx_reg <= 1'b0;
      sclk_reg <= 1'b0;
      fs_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      bit_reg <= bit_next;
      shtx_reg <= shtx_next;
      shrx_reg <= shrx_next;
      rxf_reg <= rxf_next;
      lvl_reg <= lvl_next;
      tx_reg <= tx_next;
      sclk_reg <= sclk_next;
      fs_reg <= fs_next;
      done_reg <= done_next;
    end
  end

  assign line_tx = tx_reg;
  assign line_sclk = sclk_reg;
  assign line_fsync = fs_reg;
  assign lnk.rx_frame = rxf_reg;
  assign lnk.frame_done = done_reg;
endmodule
`default_nettype wire

// >>> design/daa_line_side_bringup.sv
// Register core, bring-up sequencer and status of the line-side access device
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RULE_01) Host first programs four-bit sample rate
// (RULE_02) Host then clears line-side power-down bit
// (RULE_03) Host optionally sets both monitor levels
// (RULE_04) Host waits for link ready before samples
// (RULE_05) Link disabled, power-down set after reset
// (RULE_06) No link traffic unless powered and ready
// (RULE_07) One link carries samples, control, ring, caller ID
// (RULE_08) Loop current field reported while off-hook
// (RULE_09) Host checks dropout when loop reads zero
// (RULE_10) Filter corners scale with sample rate
// (RULE_11) Loop code steps per measured line code
// (RULE_12) Code all ones means excessive current
// (RULE_13) Maximum loop code raises overload flag
// (RULE_14) Link ready read-only, cleared on power-down
module daa_line_side_bringup #(
  parameter int SETTLE_CYCLES = daa_pkg::SETTLE_CYCLES,
  parameter int BIT_DIV = daa_pkg::BIT_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [15:0] tx_sample,
  input wire logic tx_valid,
  output logic tx_taken,
  output logic [15:0] rx_sample,
  output logic rx_valid,
  output logic ring_detect,
  output logic line_side_powerdown,
  input wire logic line_rx,
  output logic line_tx,
  output logic line_sclk,
  output logic line_fsync
);
  localparam int FB = daa_pkg::FRAME_BITS;
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_chk
    $error("daa_line_side_bringup: SETTLE_CYCLES out of range");
  end

  function automatic logic [15:0] corner_hz(input logic [3:0] code, input int num,
                                            input int den);
    int rate;
    rate = daa_pkg::RATE_BASE_HZ + int'(code) * daa_pkg::RATE_STEP_HZ;
    return 16'((rate * num) / den);
  endfunction

  link_if #(.FRAME_BITS(FB)) lnk ();

  isolation_link #(.BIT_DIV(BIT_DIV), .FRAME_BITS(FB)) u_link (
    .clk(clk),
    .rst(rst),
    .lnk(lnk),
    .line_rx(line_rx),
    .line_tx(line_tx),
    .line_sclk(line_sclk),
    .line_fsync(line_fsync)
  );

  daa_pkg::power_state_t pwr_reg, pwr_next;
  logic [15:0] settle_reg, settle_next;
  logic pd_reg, pd_next, hook_reg, hook_next;
  logic [3:0] rate_reg, rate_next;
  logic [7:0] rxmon_reg, rxmon_next, txmon_reg, txmon_next;
  logic [7:0] mask_reg, mask_next, stat_reg, stat_next;
  logic [4:0] loop_reg, loop_next;
  logic cid_reg, cid_next, ring_reg, ring_next;
  logic [15:0] txh_reg, txh_next, rxs_reg, rxs_next;
  logic taken_reg, taken_next, rxv_reg, rxv_next, irq_reg, irq_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] rd_mux;
  logic [5:0] idx;
  logic wr_fire, ready, frame_in;
  logic [4:0] rx_loop;

  assign idx = avs_address[7:2];
  assign wr_fire = avs_write && !wait_reg;
  assign ready = (pwr_reg == daa_pkg::PWR_READY);
  assign frame_in = lnk.frame_done && ready;
  assign rx_loop = lnk.rx_frame[daa_pkg::RXF_LOOP +: daa_pkg::LOOP_W];

  // Link only runs once powered up and reported ready
  assign lnk.enable = ready && !pd_reg; // RULE_06
  // Samples, monitor levels, rate and hook share one outbound frame
  assign lnk.tx_frame = {txh_reg, rxmon_reg, txmon_reg, rate_reg, hook_reg, 3'b000}; // RULE_07

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      daa_pkg::IDX_INT_MASK: rd_mux[7:0] = mask_reg;
      daa_pkg::IDX_INT_STATUS: rd_mux[7:0] = stat_reg;
      daa_pkg::IDX_HOOK: begin
        rd_mux[daa_pkg::HOOK_OFF_BIT] = hook_reg;
        rd_mux[daa_pkg::HOOK_RING_BIT] = ring_reg;
      end
      daa_pkg::IDX_POWER: rd_mux[daa_pkg::POWERDOWN_BIT] = pd_reg;
      daa_pkg::IDX_RATE: rd_mux[3:0] = rate_reg;
      daa_pkg::IDX_CORNER: begin
        rd_mux[31:16] = corner_hz(rate_reg, daa_pkg::CORNER3_NUM, daa_pkg::CORNER3_DEN); // RULE_10
        rd_mux[15:0] = corner_hz(rate_reg, daa_pkg::CORNER01_NUM,
                                 daa_pkg::CORNER01_DEN); // RULE_10
      end
      daa_pkg::IDX_LINE_STATUS: begin
        rd_mux[daa_pkg::READY_BIT] = ready;
        rd_mux[daa_pkg::CID_BIT] = cid_reg;
        rd_mux[4:0] = loop_reg;
      end
      daa_pkg::IDX_RX_MON: rd_mux[7:0] = rxmon_reg;
      daa_pkg::IDX_TX_MON: rd_mux[7:0] = txmon_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave: one wait cycle, then the request is taken
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  // Control registers and power sequencer
  always_comb begin
    pd_next = pd_reg;
    rate_next = rate_reg;
    rxmon_next = rxmon_reg;
    txmon_next = txmon_reg;
    mask_next = mask_reg;
    hook_next = hook_reg;
    pwr_next = pwr_reg;
    settle_next = settle_reg;
    if (wr_fire) begin
      unique case (idx)
        daa_pkg::IDX_INT_MASK: mask_next = avs_writedata[7:0];
        daa_pkg::IDX_HOOK: hook_next = avs_writedata[daa_pkg::HOOK_OFF_BIT];
        daa_pkg::IDX_POWER: pd_next = avs_writedata[daa_pkg::POWERDOWN_BIT];
        daa_pkg::IDX_RATE: rate_next = avs_writedata[3:0];
        daa_pkg::IDX_RX_MON: rxmon_next = avs_writedata[7:0];
        daa_pkg::IDX_TX_MON: txmon_next = avs_writedata[7:0];
        default: ;
      endcase
    end
    unique case (pwr_reg)
      daa_pkg::PWR_DOWN: begin
        settle_next = 16'h0000;
        if (!pd_reg) pwr_next = daa_pkg::PWR_SETTLE;
      end
      daa_pkg::PWR_SETTLE: begin
        settle_next = settle_reg + 16'h0001;
        if (pd_reg) pwr_next = daa_pkg::PWR_DOWN;
        else if (settle_reg == 16'(SETTLE_CYCLES - 1)) pwr_next = daa_pkg::PWR_READY;
      end
      daa_pkg::PWR_READY: begin
        if (pd_reg) pwr_next = daa_pkg::PWR_DOWN; // RULE_14
      end
      default: pwr_next = daa_pkg::PWR_DOWN;
    endcase
  end

  // Line status, samples and interrupts
  always_comb begin
    loop_next = loop_reg;
    cid_next = cid_reg;
    ring_next = ring_reg;
    rxs_next = rxs_reg;
    rxv_next = 1'b0;
    txh_next = txh_reg;
    taken_next = 1'b0;
    stat_next = stat_reg;
    if (wr_fire && idx == daa_pkg::IDX_INT_STATUS) stat_next = stat_reg & ~avs_writedata[7:0];
    if (!ready) begin
      loop_next = 5'h00;
      cid_next = 1'b0;
      ring_next = 1'b0;
    end else begin
      if (tx_valid && !taken_reg) begin
        txh_next = tx_sample;
        taken_next = 1'b1;
      end
      if (frame_in) begin
        rxs_next = lnk.rx_frame[daa_pkg::RXF_SAMPLE +: 16]; // RULE_07
        rxv_next = 1'b1;
        ring_next = lnk.rx_frame[daa_pkg::RXF_RING]; // RULE_07
        cid_next = lnk.rx_frame[daa_pkg::RXF_CID]; // RULE_07
        loop_next = hook_reg ? rx_loop : 5'h00; // RULE_08 RULE_11
        if (lnk.rx_frame[daa_pkg::RXF_DROP]) stat_next[daa_pkg::INT_DROPOUT_BIT] = 1'b1;
        if (hook_reg && rx_loop == daa_pkg::LOOP_MAX) begin
          stat_next[daa_pkg::INT_OVERLOAD_BIT] = 1'b1; // RULE_12 RULE_13
        end
      end
    end
    if (!hook_reg) loop_next = 5'h00; // RULE_08
    irq_next = |(stat_next & mask_reg);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      pd_reg <= daa_pkg::POWERDOWN_RESET; // RULE_05
      rate_reg <= daa_pkg::RATE_RESET;
      rxmon_reg <= daa_pkg::MON_RESET;
      txmon_reg <= daa_pkg::MON_RESET;
      mask_reg <= daa_pkg::MASK_RESET;
      hook_reg <= 1'b0;
      pwr_reg <= daa_pkg::PWR_DOWN; // RULE_05
      settle_reg <= 16'h0000;
      loop_reg <= 5'h00;
      cid_reg <= 1'b0;
      ring_reg <= 1'b0;
      rxs_reg <= 16'h0000;
      rxv_reg <= 1'b0;
      txh_reg <= 16'h0000;
      taken_reg <= 1'b0;
      stat_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      pd_reg <= pd_next;
      rate_reg <= rate_next;
      rxmon_reg <= rxmon_next;
      txmon_reg <= txmon_next;
      mask_reg <= mask_next;
      hook_reg <= hook_next;
      pwr_reg <= pwr_next;
      settle_reg <= settle_next;
      loop_reg <= loop_next;
      cid_reg <= cid_next;
      ring_reg <= ring_next;
      rxs_reg <= rxs_next;
      rxv_reg <= rxv_next;
      txh_reg <= txh_next;
      taken_reg <= taken_next;
      stat_reg <= stat_next;
      irq_reg <= irq_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign irq = irq_reg;
  assign tx_taken = taken_reg;
  assign rx_sample = rxs_reg;
  assign rx_valid = rxv_reg;
  assign ring_detect = ring_reg;
  assign line_side_powerdown = pd_reg;

  sequence s_rst_release;
    $fell(rst);
  endsequence
  property p_reset_disabled;
    @(posedge clk) s_rst_release |-> pd_reg && !lnk.enable && pwr_reg == daa_pkg::PWR_DOWN;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("link not off after reset"); // RULE_05

  property p_no_traffic;
    @(posedge clk) disable iff (rst) (line_fsync || lnk.frame_done) |-> $past(!pd_reg && ready);
  endproperty
  a_no_traffic: assert property (p_no_traffic) else $error("link traffic while not ready"); // RULE_06

  property p_frame_sample;
    @(posedge clk) disable iff (rst) frame_in |=> rx_valid && rx_sample == $past(lnk.rx_frame[39:24]);
  endproperty
  a_frame_sample: assert property (p_frame_sample) else $error("rx sample not delivered"); // RULE_07

  property p_onhook_zero;
    @(posedge clk) disable iff (rst) !hook_reg |=> loop_reg == 5'h00;
  endproperty
  a_onhook_zero: assert property (p_onhook_zero) else $error("loop code while on-hook"); // RULE_08

  property p_loop_code;
    @(posedge clk) disable iff (rst) (frame_in && hook_reg && !wr_fire) |=> loop_reg == $past(rx_loop);
  endproperty
  a_loop_code: assert property (p_loop_code) else $error("loop code not reported"); // RULE_11

  // Flag must stand on the cycle after the set and stay unless the host cleared it then
  property p_overload;
    @(posedge clk) disable iff (rst) (frame_in && hook_reg && rx_loop == daa_pkg::LOOP_MAX)
      |=> stat_reg[daa_pkg::INT_OVERLOAD_BIT]
      ##1 (stat_reg[daa_pkg::INT_OVERLOAD_BIT] ||
           $past(wr_fire && idx == daa_pkg::IDX_INT_STATUS && avs_writedata[2]));
  endproperty
  a_overload: assert property (p_overload) else $error("overload flag not raised"); // RULE_12

  property p_overload_cause;
    @(posedge clk) disable iff (rst)
      $rose(stat_reg[2]) |-> $past(frame_in && hook_reg && rx_loop == daa_pkg::LOOP_MAX);
  endproperty
  a_overload_cause: assert property (p_overload_cause) else $error("overload flag spurious"); // RULE_13

  sequence s_powerdown;
    ready ##1 pd_reg;
  endsequence
  property p_ready_clears;
    @(posedge clk) disable iff (rst) s_powerdown |=> !ready && !lnk.enable;
  endproperty
  a_ready_clears: assert property (p_ready_clears) else $error("ready kept on power-down"); // RULE_14

  property p_corner;
    @(posedge clk) disable iff (rst) (!avs_waitrequest && $past(avs_read && idx == 6'h08))
      |-> avs_readdata[15:0] == 16'(((7200 + 400 * int'(rate_reg)) * 33) / 80);
  endproperty
  a_corner: assert property (p_corner) else $error("corner readback wrong"); // RULE_10
endmodule
`default_nettype wire

// >>> test/line_side_model.sv
// Behavioural model of the line-side device at the far end of the isolation link
`timescale 1ns/1ps
`default_nettype none
module line_side_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic line_tx,
  input wire logic line_sclk,
  input wire logic line_fsync,
  input wire logic powered_down,
  input wire logic rx_level,
  output logic line_rx,
  output logic [39:0] out_frame,
  output logic [7:0] frame_count
);
  logic sclk_q;
  logic toggle;
  logic [5:0] nbits;
  logic [38:0] shreg;

  // A powered-down far side releases the pin, so show a changing pattern
  assign line_rx = powered_down ? toggle : rx_level;

  // Capture outbound frames MSB first, aligned on the frame sync bit
  always @(posedge clk) begin
    sclk_q <= line_sclk;
    toggle <= ~toggle;
    if (rst) begin
      nbits <= 6'h00;
      shreg <= 39'h0;
      out_frame <= 40'h0;
      frame_count <= 8'h00;
      toggle <= 1'b0;
    end else if (line_sclk && !sclk_q) begin
      nbits <= line_fsync ? 6'h01 : nbits + 6'h01;
      shreg <= line_fsync ? {38'h0, line_tx} : {shreg[37:0], line_tx};
      if (!line_fsync && nbits == 6'h27) begin
        out_frame <= {shreg, line_tx};
        frame_count <= frame_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the line-side bring-up block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  localparam int SETTLE = 20;
  localparam int DIV = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] tx_sample = 16'h0000;
  logic tx_valid = 1'b0;
  logic rx_level = 1'b0;
  logic [31:0] avs_readdata;
  logic [15:0] rx_sample;
  logic [39:0] out_frame;
  logic [7:0] frame_count;
  logic avs_waitrequest, irq, tx_taken, rx_valid, ring_detect, line_side_powerdown;
  logic line_rx, line_tx, line_sclk, line_fsync;
  int n_fail = 0;
  int samples_checked = 0;

  daa_line_side_bringup #(.SETTLE_CYCLES(SETTLE), .BIT_DIV(DIV)) DUT (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .tx_sample(tx_sample),
    .tx_valid(tx_valid), .tx_taken(tx_taken), .rx_sample(rx_sample), .rx_valid(rx_valid),
    .ring_detect(ring_detect), .line_side_powerdown(line_side_powerdown),
    .line_rx(line_rx), .line_tx(line_tx), .line_sclk(line_sclk), .line_fsync(line_fsync));

  line_side_model far (
    .clk(clk), .rst(rst), .line_tx(line_tx), .line_sclk(line_sclk),
    .line_fsync(line_fsync), .powered_down(line_side_powerdown), .rx_level(rx_level),
    .line_rx(line_rx), .out_frame(out_frame), .frame_count(frame_count));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) n_fail++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 4000) begin
      @(posedge clk);
      k++;
      if (rx_valid === 1'b1) n--;
    end
    if (n > 0) n_fail++;
  endtask

  task automatic wait_frames(input int n);
    logic [7:0] f;
    f = frame_count + 8'(n);
    repeat (4000) if (frame_count !== f) @(posedge clk);
    `CHK(frame_count, f)
  endtask

  task automatic t_reset();
    `CHK(line_side_powerdown, 1'b1)
    `CHK({line_sclk, line_fsync, line_tx, irq}, 4'h0)
    rchk(8'h18, 32'h10);
    rchk(8'h1c, 32'h0);
    rchk(8'h50, 32'h0);
    rchk(8'h54, 32'h0);
    rchk(8'h0c, 32'h0);
    rchk(8'h30, 32'h0);
    rchk(8'hfc, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_bringup();
    int unsigned r;
    int k;
    logic [31:0] q;
    time t0;
    for (int c = 0; c < 16; c++) begin
      r = daa_pkg::RATE_BASE_HZ + daa_pkg::RATE_STEP_HZ * c;
      wr(8'h1c, 32'(c));
      rchk(8'h20, {16'(r * 9 / 20), 16'(r * 33 / 80)});
    end
    wr(8'h1c, 32'h2);
    wr(8'h50, 32'hffff_ff5a);
    wr(8'h54, 32'ha5);
    rchk(8'h50, 32'h5a);
    rchk(8'h54, 32'ha5);
    wr(8'h18, 32'h0);
    t0 = $time;
    rchk(8'h30, 32'h0);
    `CHK(line_sclk, 1'b0)
    q = 32'h0;
    k = 0;
    while (q[6] !== 1'b1 && k < 100) begin
      xfer(1'b0, 8'h30, 32'h0, q);
      k++;
    end
    `CHK(q[6], 1'b1)
    `CHK(($time - t0) >= SETTLE * 5, 1'b1)
    wr(8'h30, 32'h0);
    rchk(8'h30, 32'h40);
    $display("t_bringup done");
  endtask

  task automatic t_traffic();
    int k;
    rx_level <= 1'b1;
    tx_sample <= 16'hbeef;
    tx_valid <= 1'b1;
    k = 0;
    while (tx_taken !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    `CHK(tx_taken, 1'b1)
    wait_rx(2);
    `CHK(rx_sample, 16'hffff)
    `CHK(ring_detect, 1'b1)
    rchk(8'h30, 32'h60);
    rchk(8'h10, 32'h08);
    wr(8'h14, 32'h1);
    wait_rx(2);
    rchk(8'h14, 32'h5);
    rchk(8'h30, 32'h7f);
    rchk(8'h10, 32'h0c);
    `CHK(irq, 1'b0)
    wr(8'h0c, 32'h04);
    @(posedge clk);
    `CHK(irq, 1'b1)
    wait_frames(2);
    `CHK(out_frame, {16'hbeef, 8'h5a, 8'ha5, 4'h2, 1'b1, 3'b000})
    rx_level <= 1'b0;
    wait_rx(2);
    `CHK(rx_sample, 16'h0000)
    wr(8'h10, 32'h0c);
    rchk(8'h10, 32'h0);
    rchk(8'h30, 32'h40);
    `CHK(irq, 1'b0)
    $display("t_traffic done");
  endtask

  task automatic t_powerdown();
    logic act;
    wr(8'h18, 32'h10);
    `CHK(line_side_powerdown, 1'b1)
    rchk(8'h30, 32'h0);
    act = 1'b0;
    repeat (400) begin
      @(posedge clk);
      act = act | line_sclk | line_fsync | line_tx | tx_taken | rx_valid;
    end
    `CHK(act, 1'b0)
    $display("t_powerdown done");
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bringup();
    t_traffic();
    t_powerdown();
    tally_and_finish();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    #60000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
